// File: hdl/cspc_core.v
// Purpose: Conversion start, power-down and reference enable control
// Assumes: All pin inputs synchronous to ref_clk; APB slave for registers
// Notes: Conversion is self-timed; power-down waits for it to finish
`timescale 1ns/1ps
`include "cspc_defs.vh"
module cspc_core #(
  parameter CONV_CYCLES = `CSPC_CONV_CYCLES,
  parameter ACQ_CYCLES = `CSPC_ACQ_CYCLES,
  parameter ID_VALUE = `CSPC_ID_VALUE
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Converter pins
  input wire conversion_start_n,
  input wire power_down_request,
  input wire reference_off,
  input wire ref_buffer_off,
  input wire chip_select_n,
  input wire read_enable_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Analog control outputs
  output reg busy,
  output reg sample_hold,
  output reg core_power_en,
  output reg core_low_power,
  output reg bandgap_en,
  output reg buffer_en,
  output reg temp_sensor_en,
  output reg conversion_done
);
  localparam ST_IDLE = 2'd0;
  localparam ST_CONV = 2'd1;
  localparam ST_ACQ = 2'd2;
  localparam ST_PD = 2'd3;

  reg [1:0] state;
  reg [1:0] next_state;
  reg start_prev;
  reg [31:0] ctrl;
  reg pd_pending;
  reg [15:0] conv_count;
  reg [11:0] acq_count;
  wire start_fall;
  wire pd_want;
  wire timer_load;
  wire timer_running;
  wire timer_done;
  wire apb_access;
  wire apb_write;
  wire apb_read;
  wire apb_commit;

  // Register decode used by both read and write paths
  function addr_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      addr_hit = (addr[11:2] == offset[11:2]);
    end
  endfunction

  // Chip-select and read-enable deliberately unused by start logic
  assign start_fall = start_prev & ~conversion_start_n;
  assign pd_want = ctrl[`CSPC_CTRL_PD_SEL] ? ctrl[`CSPC_CTRL_PD_SW]
                                           : power_down_request;
  assign timer_load = start_fall && (state != ST_CONV) && (state != ST_PD);
  assign apb_access = psel & penable & ~pready;
  assign apb_write = apb_access & pwrite;
  assign apb_read = apb_access & ~pwrite;
  assign apb_commit = psel & penable & pready & pwrite;

  cspc_timer #(
    .WIDTH(12)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(timer_load),
    .load_value(CONV_CYCLES[11:0]),
    .running(timer_running),
    .done(timer_done)
  );

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_prev <= 1'b1;
    end else begin
      start_prev <= conversion_start_n;
    end
  end

  // Conversion sequencing; a start during conversion is ignored
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (timer_load) begin
          next_state = ST_CONV;
        end else if (pd_want) begin
          next_state = ST_PD;
        end
      end
      ST_CONV: begin
        if (timer_done) begin
          if (pd_want || pd_pending) begin
            next_state = ST_PD;
          end else begin
            next_state = ST_ACQ;
          end
        end
      end
      ST_ACQ: begin
        if (timer_load) begin
          next_state = ST_CONV;
        end else if (pd_want) begin
          next_state = ST_PD;
        end else if (acq_count == 12'h000) begin
          next_state = ST_IDLE;
        end
      end
      ST_PD: begin
        if (!pd_want) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      pd_pending <= 1'b0;
      acq_count <= 12'h000;
      conv_count <= 16'h0000;
      conversion_done <= 1'b0;
    end else begin
      state <= next_state;
      conversion_done <= timer_done;
      if (state == ST_CONV && pd_want) begin
        pd_pending <= 1'b1;
      end else if (state != ST_CONV) begin
        pd_pending <= 1'b0;
      end
      if (timer_done) begin
        acq_count <= ACQ_CYCLES[11:0];
        conv_count <= conv_count + 16'h0001;
      end else if (acq_count != 12'h000) begin
        acq_count <= acq_count - 12'h001;
      end
    end
  end

  // Output registers, derived from next state so they align with state
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      sample_hold <= 1'b0;
      core_power_en <= 1'b1;
      core_low_power <= 1'b0;
      bandgap_en <= 1'b0;
      buffer_en <= 1'b0;
      temp_sensor_en <= 1'b0;
    end else begin
      busy <= (next_state == ST_CONV);
      sample_hold <= (next_state == ST_CONV);
      core_power_en <= (next_state != ST_PD);
      core_low_power <= ctrl[`CSPC_CTRL_LOWPWR] && (next_state != ST_CONV);
      bandgap_en <= ~reference_off && (next_state != ST_PD);
      buffer_en <= ~ref_buffer_off && (next_state != ST_PD);
      temp_sensor_en <= ~reference_off && ~ref_buffer_off && (next_state != ST_PD);
    end
  end

  // APB slave stays live in every state, including power-down and acquisition
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= `CSPC_CTRL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access;
      pslverr <= 1'b0;
      // Control word lands on the edge that completes the transfer
      if (apb_commit && addr_hit(paddr, `CSPC_OFF_CTRL)) begin
        ctrl <= {29'h0000_0000, pwdata[2:0]};
      end
      if (apb_write) begin
        if (addr_hit(paddr, `CSPC_OFF_CTRL)) begin
          pslverr <= 1'b0;
        end else if (!addr_hit(paddr, `CSPC_OFF_STATUS) &&
                     !addr_hit(paddr, `CSPC_OFF_COUNT) &&
                     !addr_hit(paddr, `CSPC_OFF_ID)) begin
          pslverr <= 1'b1;
        end
      end
      if (apb_read) begin
        if (addr_hit(paddr, `CSPC_OFF_CTRL)) begin
          prdata <= ctrl;
        end else if (addr_hit(paddr, `CSPC_OFF_STATUS)) begin
          prdata <= {24'h00_0000, conversion_start_n, temp_sensor_en, buffer_en,
                     bandgap_en, core_low_power, pd_pending, (state == ST_PD),
                     timer_running};
        end else if (addr_hit(paddr, `CSPC_OFF_COUNT)) begin
          prdata <= {16'h0000, conv_count};
        end else if (addr_hit(paddr, `CSPC_OFF_ID)) begin
          prdata <= ID_VALUE;
        end else begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1;
        end
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule // cspc_core

// File: hdl/cspc_defs.vh
// Purpose: Constants for the conversion start and power control block
// Assumes: 200 MHz ref_clk, APB with 32-bit data
// Notes: Offsets are byte addresses
`ifndef CSPC_DEFS_VH
`define CSPC_DEFS_VH
`define CSPC_CLK_MHZ 200
`define CSPC_CONV_TIME_NS 1500
`define CSPC_CONV_CYCLES ((`CSPC_CONV_TIME_NS * `CSPC_CLK_MHZ) / 1000)
`define CSPC_ACQ_TIME_NS 250
`define CSPC_ACQ_CYCLES ((`CSPC_ACQ_TIME_NS * `CSPC_CLK_MHZ + 999) / 1000)
`define CSPC_OFF_CTRL 12'h000
`define CSPC_OFF_STATUS 12'h004
`define CSPC_OFF_COUNT 12'h008
`define CSPC_OFF_ID 12'h00C
`define CSPC_CTRL_PD_SW 0
`define CSPC_CTRL_PD_SEL 1
`define CSPC_CTRL_LOWPWR 2
`define CSPC_CTRL_RESET 32'h0000_0000
// Identification value is arbitrary
`define CSPC_ID_VALUE 32'h0000_A5C3
`define CSPC_ST_BUSY 0
`define CSPC_ST_PD 1
`define CSPC_ST_PEND 2
`define CSPC_ST_CORE_LP 3
`define CSPC_ST_REF_EN 4
`define CSPC_ST_BUF_EN 5
`define CSPC_ST_TEMP_EN 6
`define CSPC_ST_CNV_N 7
`endif

// File: hdl/cspc_timer.v
// Purpose: Down counter timing the conversion phase
// Assumes: load has priority over counting
// Notes: done pulses one cycle when the count expires
`timescale 1ns/1ps
module cspc_timer #(
  parameter WIDTH = 12
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Control
  input wire load,
  input wire [WIDTH-1:0] load_value,
  // Status
  output reg running,
  output reg done
);
  reg [WIDTH-1:0] count;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= {WIDTH{1'b0}};
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        count <= load_value;
        running <= 1'b1;
      end else if (running) begin
        if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done <= 1'b1;
          count <= {WIDTH{1'b0}};
        end else begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // cspc_timer

// File: tb/cspc_core_assertions.sv
// Purpose: Port checks for cspc_core
// Assumes: CONV_CYCLES as instanced
// Notes: Bound from the bench top
`timescale 1ns/1ps
module cspc_core_assertions #(
  parameter CONV_CYCLES = 20
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  // Pins and bus
  input wire reference_off,
  input wire psel,
  input wire penable,
  input wire pready,
  // Control outputs
  input wire busy,
  input wire conversion_done,
  input wire core_power_en,
  input wire core_low_power,
  input wire bandgap_en,
  input wire buffer_en,
  input wire temp_sensor_en
);
  localparam int LO = CONV_CYCLES - 2;
  localparam int HI = CONV_CYCLES + 1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_busy_span: assert property ($rose(busy) |-> busy throughout (1 ##[LO:LO] 1))
    else $error("busy short");
  chk_busy_end: assert property ($rose(busy) |-> ##[LO:HI] conversion_done)
    else $error("no done");
  chk_done_edge: assert property (conversion_done |-> !busy && $past(busy))
    else $error("done misplaced");
  chk_power_conv: assert property (busy |-> core_power_en)
    else $error("power off in conversion");
  chk_ref_follow: assert property ($past(rst_b) && $past(core_power_en) && core_power_en
    |-> bandgap_en == !$past(reference_off)) else $error("bandgap");
  chk_temp_pair: assert property (temp_sensor_en == (bandgap_en && buffer_en))
    else $error("temp enable");
  chk_bus_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer");
  chk_low_idle: assert property (core_low_power |-> !busy)
    else $error("low power in conversion");
endmodule // cspc_core_assertions

// File: tb/cspc_host.sv
// Purpose: Host model driving the start pin
// Assumes: Pin moves just after a rising edge
// Notes: Pin idles high, low for 3 cycles
`timescale 1ns/1ps
module cspc_host (
  // Clock
  input wire ref_clk,
  // Start pin
  output reg conversion_start_n
);
  initial conversion_start_n = 1'b1;
  task pulse;
    begin
      @(posedge ref_clk);
      conversion_start_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      conversion_start_n <= 1'b1;
    end
  endtask
endmodule // cspc_host

// File: tb/test_conversion_start_power_control.sv
// Purpose: Self-checking bench for cspc_core
// Assumes: Conversion shortened to 20 cycles
// Notes: Host model makes the start edges
`timescale 1ns/1ps
module test_conversion_start_power_control;
  logic ref_clk = 1'b0, rst_b = 1'b0, power_down_request = 1'b0;
  logic reference_off = 1'b0, ref_buffer_off = 1'b0, chip_select_n = 1'b0;
  logic read_enable_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic pready, pslverr, slv, busy, conversion_done, conversion_start_n, sample_hold;
  logic core_power_en, core_low_power, bandgap_en, buffer_en, temp_sensor_en;
  int err_total = 0, n_tests = 0, wcnt = 0;
  always #2.5 ref_clk = ~ref_clk;
  cspc_host cspc_host_i (.ref_clk, .conversion_start_n);
  // Identity value is arbitrary
  cspc_core #(.CONV_CYCLES(20), .ACQ_CYCLES(5), .ID_VALUE(32'h0000_1234)) cspc_core_i (
    .ref_clk, .rst_b, .conversion_start_n, .power_down_request, .reference_off,
    .ref_buffer_off, .chip_select_n, .read_enable_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .busy, .sample_hold, .core_power_en,
    .core_low_power, .bandgap_en, .buffer_en, .temp_sensor_en, .conversion_done
  );
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      n_tests++;
      if (g !== e) begin
        err_total++;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task bail;
    begin
      err_total++;
      $display("[FAIL] %0t wait timed out", $time);
      give_verdict;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge ref_clk);
        k++;
      end while (pready !== 1'b1 && k < 20);
      rdat = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) bail;
    end
  endtask
  task wb(input logic v);
    int k;
    begin
      k = 0;
      while (busy !== v && k < 100) begin
        @(posedge ref_clk);
        k++;
      end
      wcnt = k;
      if (k >= 100) bail;
    end
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    apb(1'b0, 12'h00C, 32'h0);
    chk(rdat, 32'h0000_1234);
    apb(1'b0, 12'h010, 32'h0);
    chk(slv, 1'b1);
    chk(rdat, 32'h0000_0000);
    apb(1'b1, 12'h010, 32'h0);
    chk(slv, 1'b1);
    $display("bus test done");
    for (int i = 0; i < 4; i++) begin
      {reference_off, ref_buffer_off} <= i[1:0];
      repeat (3) @(posedge ref_clk);
      chk({bandgap_en, buffer_en, temp_sensor_en}, {~i[1], ~i[0], i == 0});
    end
    $display("reference test done");
    chip_select_n <= 1'b1;
    read_enable_n <= 1'b1;
    cspc_host_i.pulse();
    chk(busy, 1'b1);
    chk(sample_hold, 1'b1);
    cspc_host_i.pulse();
    wb(1'b0);
    // First start was six edges back; a restart would push the end out past 17
    chk(wcnt <= 17, 1'b1);
    chk(sample_hold, 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rdat, 32'h1);
    $display("start test done");
    cspc_host_i.pulse();
    power_down_request <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk(rdat[2:0], 3'b101);
    wb(1'b0);
    repeat (3) @(posedge ref_clk);
    chk(core_power_en, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rdat[1], 1'b1);
    cspc_host_i.pulse();
    chk(busy, 1'b0);
    power_down_request <= 1'b0;
    apb(1'b1, 12'h000, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk(core_power_en, 1'b0);
    power_down_request <= 1'b1;
    apb(1'b1, 12'h000, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk(core_power_en, 1'b1);
    power_down_request <= 1'b0;
    apb(1'b1, 12'h000, 32'h4);
    $display("power test done");
    cspc_host_i.pulse();
    wb(1'b0);
    repeat (2) @(posedge ref_clk);
    chk(core_low_power, 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    chk({rdat[3], rdat[0]}, 2'b10);
    $display("low power test done");
    give_verdict;
  end
endmodule // test_conversion_start_power_control
bind cspc_core cspc_core_assertions #(.CONV_CYCLES(CONV_CYCLES)) cspc_core_assertions_i (
  .ref_clk, .rst_b, .reference_off, .psel, .penable, .pready, .busy, .conversion_done,
  .core_power_en, .core_low_power, .bandgap_en, .buffer_en, .temp_sensor_en
);
